// >>> common/ivmap_pkg.sv
// Constants, vector numbers and helpers for the interrupt vector map
package ivmap_pkg;
	localparam int unsigned REQ_N = 64;                 // Request lines, bit k is vector k+1
	localparam int unsigned RST_SRC_N = 5;              // Reset sources
	localparam int unsigned VEC_W = 7;                  // Vector number width
	localparam int unsigned ADDR_W = 17;                // Program word address width
	localparam logic [VEC_W-1:0] RESET_VEC = 7'h00;     // Vector of every reset source
	localparam logic [ADDR_W-1:0] RESET_ADDR = 17'h00000; // Reset address with fuse unprogrammed
	// Vector numbers
	localparam logic [VEC_W-1:0] VEC_EXT_REQUEST_0 = 7'h01;
	localparam logic [VEC_W-1:0] VEC_EXT_REQUEST_7 = 7'h08;
	localparam logic [VEC_W-1:0] VEC_PIN_CHANGE_REQUEST_0 = 7'h09;
	localparam logic [VEC_W-1:0] VEC_PIN_CHANGE_REQUEST_2 = 7'h0b;
	localparam logic [VEC_W-1:0] VEC_WATCHDOG_TIMEOUT = 7'h0c;
	localparam logic [VEC_W-1:0] VEC_TIMER_TWO_COMPARE_A = 7'h0d;
	localparam logic [VEC_W-1:0] VEC_TIMER_TWO_OVERFLOW = 7'h0f;
	localparam logic [VEC_W-1:0] VEC_TIMER_ONE_CAPTURE = 7'h10;
	localparam logic [VEC_W-1:0] VEC_TIMER_ONE_OVERFLOW = 7'h14;
	localparam logic [VEC_W-1:0] VEC_TIMER_ZERO_COMPARE_A = 7'h15;
	localparam logic [VEC_W-1:0] VEC_TIMER_ZERO_OVERFLOW = 7'h17;
	localparam logic [VEC_W-1:0] VEC_SPI_TRANSFER_DONE = 7'h18;
	localparam logic [VEC_W-1:0] VEC_SERIAL0_RX_DONE = 7'h19;
	localparam logic [VEC_W-1:0] VEC_SERIAL0_TX_DONE = 7'h1b;
	localparam logic [VEC_W-1:0] VEC_NV_DATA_READY = 7'h1e;
	localparam logic [VEC_W-1:0] VEC_TIMER_THREE_CAPTURE = 7'h1f;
	localparam logic [VEC_W-1:0] VEC_TIMER_THREE_OVERFLOW = 7'h23;
	localparam logic [VEC_W-1:0] VEC_SERIAL1_RX_DONE = 7'h24;
	localparam logic [VEC_W-1:0] VEC_SERIAL1_TX_DONE = 7'h26;
	localparam logic [VEC_W-1:0] VEC_TWO_WIRE = 7'h27;
	localparam logic [VEC_W-1:0] VEC_PROGRAM_STORE_READY = 7'h28;
	localparam logic [VEC_W-1:0] VEC_TIMER_FOUR_CAPTURE = 7'h29;
	localparam logic [VEC_W-1:0] VEC_TIMER_FOUR_OVERFLOW = 7'h2d;
	localparam logic [VEC_W-1:0] VEC_TIMER_FIVE_CAPTURE = 7'h2e;
	localparam logic [VEC_W-1:0] VEC_TIMER_FIVE_OVERFLOW = 7'h32;
	localparam logic [VEC_W-1:0] VEC_RSVD_FIRST = 7'h33;
	localparam logic [VEC_W-1:0] VEC_RSVD_LAST = 7'h38;
	localparam logic [VEC_W-1:0] VEC_RADIO_PLL_LOCK = 7'h39;
	localparam logic [VEC_W-1:0] VEC_RADIO_CHANNEL_MEASURE_DONE = 7'h3d;
	localparam logic [VEC_W-1:0] VEC_RADIO_ADDR_MATCH = 7'h3e;
	localparam logic [VEC_W-1:0] VEC_RADIO_WAKEUP_DONE = 7'h40;
	// Vector word addresses
	localparam logic [ADDR_W-1:0] ADDR_EXT_REQUEST_0 = 17'h00002;
	localparam logic [ADDR_W-1:0] ADDR_EXT_REQUEST_7 = 17'h00010;
	localparam logic [ADDR_W-1:0] ADDR_PIN_CHANGE_REQUEST_0 = 17'h00012;
	localparam logic [ADDR_W-1:0] ADDR_PIN_CHANGE_REQUEST_2 = 17'h00016;
	localparam logic [ADDR_W-1:0] ADDR_WATCHDOG_TIMEOUT = 17'h00018;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_TWO_COMPARE_A = 17'h0001a;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_TWO_OVERFLOW = 17'h0001e;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_ONE_CAPTURE = 17'h00020;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_ONE_OVERFLOW = 17'h00028;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_ZERO_COMPARE_A = 17'h0002a;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_ZERO_OVERFLOW = 17'h0002e;
	localparam logic [ADDR_W-1:0] ADDR_SPI_TRANSFER_DONE = 17'h00030;
	localparam logic [ADDR_W-1:0] ADDR_SERIAL0_RX_DONE = 17'h00032;
	localparam logic [ADDR_W-1:0] ADDR_SERIAL0_TX_DONE = 17'h00036;
	localparam logic [ADDR_W-1:0] ADDR_NV_DATA_READY = 17'h0003c;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_THREE_CAPTURE = 17'h0003e;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_THREE_OVERFLOW = 17'h00046;
	localparam logic [ADDR_W-1:0] ADDR_SERIAL1_RX_DONE = 17'h00048;
	localparam logic [ADDR_W-1:0] ADDR_SERIAL1_TX_DONE = 17'h0004c;
	localparam logic [ADDR_W-1:0] ADDR_TWO_WIRE = 17'h0004e;
	localparam logic [ADDR_W-1:0] ADDR_PROGRAM_STORE_READY = 17'h00050;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_FOUR_CAPTURE = 17'h00052;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_FOUR_OVERFLOW = 17'h0005a;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_FIVE_CAPTURE = 17'h0005c;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_FIVE_OVERFLOW = 17'h00064;
	localparam logic [ADDR_W-1:0] ADDR_RADIO_PLL_LOCK = 17'h00072;
	localparam logic [ADDR_W-1:0] ADDR_RADIO_CHANNEL_MEASURE_DONE = 17'h0007a;
	localparam logic [ADDR_W-1:0] ADDR_RADIO_ADDR_MATCH = 17'h0007c;
	localparam logic [ADDR_W-1:0] ADDR_RADIO_WAKEUP_DONE = 17'h00080;

	// Two program words per vector: address is twice the number
	function automatic logic [ADDR_W-1:0] ivmap_vec_addr(input logic [VEC_W-1:0] num);
		return {9'h000, num, 1'b0};
	endfunction : ivmap_vec_addr

	// True for the reserved vector slots
	function automatic logic ivmap_is_reserved(input logic [VEC_W-1:0] num);
		return (num >= VEC_RSVD_FIRST) && (num <= VEC_RSVD_LAST);
	endfunction : ivmap_is_reserved
endpackage : ivmap_pkg

// >>> src/ivmap_prio_enc.sv
// Lowest-numbered pending request finder
`timescale 1ns/1ps
module ivmap_prio_enc
	import ivmap_pkg::*;
(
	input  wire logic [REQ_N-1:0] req_i,   // Request lines, bit k is vector k+1
	output logic                  hit_o,   // Any request pending
	output logic [VEC_W-1:0]      num_o    // Vector number of winner
);
	// Scan downward so the lowest vector number wins
	always_comb begin
		hit_o = 1'b0;
		num_o = RESET_VEC;
		for (int k = REQ_N - 1; k >= 0; k--) begin
			if (req_i[k]) begin
				hit_o = 1'b1;
				num_o = VEC_W'(k + 1);
			end
		end
	end
endmodule : ivmap_prio_enc

// >>> src/ivmap_top.sv
// Reset and interrupt vector map feeding the core's vector fetch
//
// Notes on behaviour
// [R1] Every reset source uses vector zero
// [R2] External requests 0-7 use vectors 1-8
// [R3] Pin-change requests 0-2 use vectors 9-11
// [R4] Watchdog vector 12, timer two 13-15
// [R5] Timer one uses vectors 16 to 20
// [R6] Timer zero uses vectors 21 to 23
// [R7] Serial transfer complete uses vector 24
// [R8] Serial port 0, comparator, converter, nonvolatile: 25-30
// [R9] Timer three uses vectors 31 to 35
// [R10] Second serial port uses vectors 36 to 38
// [R11] Two-wire vector 39, program store 40
// [R12] Timer four uses vectors 41 to 45
// [R13] Timer five uses vectors 46 to 50
// [R14] Radio events use vectors 57 to 61
// [R15] Radio match, transmit end, wakeup: 62-64
// [R16] Select bit adds boot start, except reset
// [R17] Programmed boot fuse sends reset to boot
// [R18] Vector address is twice vector number
// [R19] Vectors 51 to 56 never selected
`timescale 1ns/1ps
module ivmap_top
	import ivmap_pkg::*;
(
	input  wire logic                 clock_i,             // System clock
	input  wire logic                 rst_i,               // Synchronous reset, active high
	input  wire logic [RST_SRC_N-1:0] reset_src_i,         // Pin, power-on, brown-out, watchdog, test-port
	input  wire logic [REQ_N-1:0]     irq_i,               // Request lines, bit k is vector k+1
	input  wire logic                 vector_select_bit_i, // Move interrupt vectors to boot section
	input  wire logic                 boot_reset_fuse_i,   // High when boot fuse is programmed
	input  wire logic [ADDR_W-1:0]    boot_start_i,        // Boot section start word address
	output logic                      vector_valid_o,      // A vector is presented
	output logic                      reset_vector_o,      // Presented vector is the reset vector
	output logic [VEC_W-1:0]          vector_num_o,        // Vector number
	output logic [ADDR_W-1:0]         vector_addr_o        // Vector program word address
);
	logic [REQ_N-1:0] masked_req; // Requests with reserved slots removed
	logic             enc_hit;    // Some request pending
	logic [VEC_W-1:0] enc_num;    // Winning vector number
	logic             any_reset;  // Some reset source active
	logic             quiet;      // No reset, vectors not moved

	assign any_reset = |reset_src_i;
	assign quiet = !any_reset && !vector_select_bit_i;

	// Reserved slots are cut off before arbitration
	genvar g;
	generate
		for (g = 0; g < REQ_N; g++) begin : g_mask
			assign masked_req[g] = irq_i[g] & ~ivmap_is_reserved(VEC_W'(g + 1)); // [R19]
		end
	endgenerate

	// Lowest number wins, giving the fixed source order
	ivmap_prio_enc ivmap_prio_enc_i (
		.req_i (masked_req),
		.hit_o (enc_hit),
		.num_o (enc_num)
	); // [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R14] [R15]

	// Vector number and valid flags; reset outranks every request
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			vector_valid_o <= 1'b0;
			reset_vector_o <= 1'b0;
			vector_num_o   <= RESET_VEC;
		end else if (any_reset) begin
			vector_valid_o <= 1'b1;
			reset_vector_o <= 1'b1;
			vector_num_o   <= RESET_VEC; // [R1]
		end else begin
			vector_valid_o <= enc_hit;
			reset_vector_o <= 1'b0;
			vector_num_o   <= enc_hit ? enc_num : RESET_VEC;
		end
	end

	// Vector address, with boot relocation and boot reset
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			vector_addr_o <= RESET_ADDR;
		end else if (any_reset) begin
			// Select bit never moves the reset vector
			vector_addr_o <= boot_reset_fuse_i ? boot_start_i : RESET_ADDR; // [R17]
		end else if (!enc_hit) begin
			vector_addr_o <= RESET_ADDR;
		end else if (vector_select_bit_i) begin
			vector_addr_o <= ADDR_W'(boot_start_i + ivmap_vec_addr(enc_num)); // [R16] [R18]
		end else begin
			vector_addr_o <= ivmap_vec_addr(enc_num); // [R18]
		end
	end

	// One lone request on a given vector
	function automatic logic [REQ_N-1:0] lone_req(input logic [VEC_W-1:0] n);
		return REQ_N'(64'h1 << (n - 7'h01));
	endfunction : lone_req

	// Reset source with fuse unprogrammed gives vector zero and address zero
	property p_r1;
		@(posedge clock_i) disable iff (rst_i)
		(any_reset && !boot_reset_fuse_i) |=> (reset_vector_o && vector_valid_o
			&& vector_num_o == RESET_VEC && vector_addr_o == RESET_ADDR);
	endproperty
	a_r1: assert property (p_r1) else $error("reset source did not give vector zero"); // [R1]

	// Request 0 wins over the rest of its group
	property p_r2;
		@(posedge clock_i) disable iff (rst_i)
		quiet && (irq_i == lone_req(VEC_EXT_REQUEST_0) || irq_i[7:0] == 8'hff)
			|=> vector_num_o == VEC_EXT_REQUEST_0 && vector_addr_o == ADDR_EXT_REQUEST_0;
	endproperty
	a_r2: assert property (p_r2) else $error("external request 0 mapped wrong"); // [R2]

	property p_r2b;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_EXT_REQUEST_7)
			|=> vector_num_o == VEC_EXT_REQUEST_7 && vector_addr_o == ADDR_EXT_REQUEST_7;
	endproperty
	a_r2b: assert property (p_r2b) else $error("external request 7 mapped wrong"); // [R2]

	property p_r3;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_PIN_CHANGE_REQUEST_0)
			|=> vector_num_o == VEC_PIN_CHANGE_REQUEST_0 && vector_addr_o == ADDR_PIN_CHANGE_REQUEST_0;
	endproperty
	a_r3: assert property (p_r3) else $error("pin change 0 mapped wrong"); // [R3]

	property p_r3b;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_PIN_CHANGE_REQUEST_2)
			|=> vector_num_o == VEC_PIN_CHANGE_REQUEST_2 && vector_addr_o == ADDR_PIN_CHANGE_REQUEST_2;
	endproperty
	a_r3b: assert property (p_r3b) else $error("pin change 2 mapped wrong"); // [R3]

	property p_r4;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i[11:0] == 12'h800
			|=> vector_num_o == VEC_WATCHDOG_TIMEOUT && vector_addr_o == ADDR_WATCHDOG_TIMEOUT;
	endproperty
	a_r4: assert property (p_r4) else $error("watchdog vector wrong"); // [R4]

	property p_r4b;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_TIMER_TWO_OVERFLOW)
			|=> vector_addr_o == ADDR_TIMER_TWO_OVERFLOW;
	endproperty
	a_r4b: assert property (p_r4b) else $error("timer two overflow vector wrong"); // [R4]

	property p_r5;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_TIMER_ONE_OVERFLOW)
			|=> vector_num_o == VEC_TIMER_ONE_OVERFLOW && vector_addr_o == ADDR_TIMER_ONE_OVERFLOW;
	endproperty
	a_r5: assert property (p_r5) else $error("timer one overflow vector wrong"); // [R5]

	property p_r6;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_TIMER_ZERO_OVERFLOW) ##1 1'b1
			|-> vector_addr_o == ADDR_TIMER_ZERO_OVERFLOW;
	endproperty
	a_r6: assert property (p_r6) else $error("timer zero overflow vector wrong"); // [R6]

	property p_r7;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_SPI_TRANSFER_DONE)
			|=> vector_valid_o && vector_addr_o == ADDR_SPI_TRANSFER_DONE;
	endproperty
	a_r7: assert property (p_r7) else $error("transfer done vector wrong"); // [R7]

	property p_r8;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_NV_DATA_READY) |=> vector_addr_o == ADDR_NV_DATA_READY;
	endproperty
	a_r8: assert property (p_r8) else $error("nonvolatile ready vector wrong"); // [R8]

	property p_r9;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_TIMER_THREE_OVERFLOW) |=> vector_addr_o == ADDR_TIMER_THREE_OVERFLOW;
	endproperty
	a_r9: assert property (p_r9) else $error("timer three overflow vector wrong"); // [R9]

	property p_r10;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_SERIAL1_TX_DONE) |=> vector_addr_o == ADDR_SERIAL1_TX_DONE;
	endproperty
	a_r10: assert property (p_r10) else $error("second port tx vector wrong"); // [R10]

	property p_r11;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_PROGRAM_STORE_READY) |=> vector_addr_o == ADDR_PROGRAM_STORE_READY;
	endproperty
	a_r11: assert property (p_r11) else $error("program store vector wrong"); // [R11]

	property p_r12;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_TIMER_FOUR_CAPTURE) |=> vector_addr_o == ADDR_TIMER_FOUR_CAPTURE;
	endproperty
	a_r12: assert property (p_r12) else $error("timer four capture vector wrong"); // [R12]

	property p_r13;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_TIMER_FIVE_OVERFLOW) |=> vector_addr_o == ADDR_TIMER_FIVE_OVERFLOW;
	endproperty
	a_r13: assert property (p_r13) else $error("timer five overflow vector wrong"); // [R13]

	property p_r14;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_RADIO_PLL_LOCK) |=> vector_addr_o == ADDR_RADIO_PLL_LOCK;
	endproperty
	a_r14: assert property (p_r14) else $error("radio lock vector wrong"); // [R14]

	property p_r15;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i == lone_req(VEC_RADIO_WAKEUP_DONE)
			|=> vector_num_o == VEC_RADIO_WAKEUP_DONE && vector_addr_o == ADDR_RADIO_WAKEUP_DONE;
	endproperty
	a_r15: assert property (p_r15) else $error("radio wakeup vector wrong"); // [R15]

	property p_r16;
		@(posedge clock_i) disable iff (rst_i)
		(vector_valid_o && !reset_vector_o && $past(vector_select_bit_i))
			|-> vector_addr_o == ADDR_W'($past(boot_start_i) + ivmap_vec_addr(vector_num_o));
	endproperty
	a_r16: assert property (p_r16) else $error("relocated vector address wrong"); // [R16]

	property p_r17;
		@(posedge clock_i) disable iff (rst_i)
		(any_reset && boot_reset_fuse_i) |=> reset_vector_o && vector_addr_o == $past(boot_start_i);
	endproperty
	a_r17: assert property (p_r17) else $error("boot reset address wrong"); // [R17]

	property p_r18;
		@(posedge clock_i) disable iff (rst_i)
		(vector_valid_o && !reset_vector_o && !$past(vector_select_bit_i))
			|-> vector_addr_o == ivmap_vec_addr(vector_num_o);
	endproperty
	a_r18: assert property (p_r18) else $error("vector address not twice number"); // [R18]

	property p_r19;
		@(posedge clock_i) disable iff (rst_i)
		quiet && irq_i[55:50] != 6'h00 && irq_i[49:0] == 50'h0 && irq_i[63:56] == 8'h00
			|=> !vector_valid_o && !ivmap_is_reserved(vector_num_o);
	endproperty
	a_r19: assert property (p_r19) else $error("reserved vector selected"); // [R19]
endmodule : ivmap_top

// >>> bench/ivmap_core_model.sv
// Processor core model that fetches whatever vector the map presents
`timescale 1ns/1ps
module ivmap_core_model
	import ivmap_pkg::*;
(
	input  wire logic              clock_i,        // System clock
	input  wire logic              rst_i,          // Synchronous reset, active high
	input  wire logic              vector_valid_i, // A vector is presented
	input  wire logic [ADDR_W-1:0] vector_addr_i,  // Presented vector word address
	output logic      [ADDR_W-1:0] fetch_pc_o,     // Address of the last fetch
	output logic      [15:0]       fetch_cnt_o     // Number of fetches taken
);
	// Fetch on every presented vector; there is no acknowledge, the core clears sources itself
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fetch_pc_o  <= '0;
			fetch_cnt_o <= '0;
		end else if (vector_valid_i) begin
			fetch_pc_o  <= vector_addr_i;
			fetch_cnt_o <= fetch_cnt_o + 16'h0001;
		end
	end
endmodule : ivmap_core_model

// >>> bench/interrupt_vector_map_bench.sv
// Self-checking bench for the reset and interrupt vector map
`timescale 1ns/1ps
`define ivm_chk(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("unexpected %s expected %h seen %h", what, exp, got); end end
module interrupt_vector_map_bench
	import ivmap_pkg::*;
;
	logic                 clock_i;   // System clock
	logic                 rst_i;     // Synchronous reset
	logic [RST_SRC_N-1:0] reset_src; // Reset source lines
	logic [REQ_N-1:0]     irq;       // Request lines
	logic                 sel;       // Vector select bit
	logic                 fuse;      // Boot fuse programmed
	logic [ADDR_W-1:0]    boot;      // Boot start address
	logic                 valid;     // Vector presented
	logic                 is_rst;    // Reset vector presented
	logic [VEC_W-1:0]     num;       // Vector number
	logic [ADDR_W-1:0]    addr;      // Vector address
	logic [ADDR_W-1:0]    fetch_pc;  // Core model's last fetch
	logic [15:0]          fetch_cnt; // Core model's fetch count
	logic [25:0]          exp_v;     // Expected valid, reset, number, address
	logic [31:0]          seed;      // Random state
	int                   n_errors;  // Mismatches seen
	int                   num_checks; // Comparisons made

	// Design under test
	ivmap_top ivmap_top_i (.clock_i(clock_i), .rst_i(rst_i), .reset_src_i(reset_src), .irq_i(irq),
		.vector_select_bit_i(sel), .boot_reset_fuse_i(fuse), .boot_start_i(boot), .vector_valid_o(valid),
		.reset_vector_o(is_rst), .vector_num_o(num), .vector_addr_o(addr));

	// Core on the far side
	ivmap_core_model ivmap_core_model_i (.clock_i(clock_i), .rst_i(rst_i), .vector_valid_i(valid),
		.vector_addr_i(addr), .fetch_pc_o(fetch_pc), .fetch_cnt_o(fetch_cnt));

	// Next random word
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	// Expected outputs worked out from the vector table
	function automatic logic [25:0] expect_out(input logic [4:0] src, input logic [63:0] req,
		input logic s, input logic f, input logic [16:0] b);
		logic [63:0] live;
		logic [6:0]  n;
		live = req & ~(64'h3f << 50);
		n = 7'h00;
		if (src != 5'h00) return {2'b11, 7'h00, f ? b : 17'h00000};
		for (int k = 63; k >= 0; k--) begin
			if (live[k]) n = 7'(k + 1);
		end
		if (n == 7'h00) return '0;
		return {2'b10, n, {9'h000, n, 1'b0} + (s ? b : 17'h00000)};
	endfunction : expect_out

	// Present one set of inputs and compare the registered answer one edge later
	task automatic apply(input logic [4:0] src, input logic [63:0] req, input logic s, input logic f,
		input logic [16:0] b);
		@(posedge clock_i);
		reset_src <= src;
		irq       <= req;
		sel       <= s;
		fuse      <= f;
		boot      <= b;
		exp_v = expect_out(src, req, s, f, b);
		@(posedge clock_i);
		#1;
		`ivm_chk("vector_valid_o", exp_v[25], valid)
		`ivm_chk("reset_vector_o", exp_v[24], is_rst)
		`ivm_chk("vector_num_o", exp_v[23:17], num)
		`ivm_chk("vector_addr_o", exp_v[16:0], addr)
	endtask : apply

	// Print the counts and the verdict, then stop
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// Clock at 20 MHz
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	// Watchdog against a hang
	initial begin
		repeat (6000) @(posedge clock_i);
		n_errors++;
		close_out();
	end

	// Main sequence
	initial begin
		rst_i = 1'b1;
		reset_src = '0;
		irq = '0;
		sel = 1'b0;
		fuse = 1'b0;
		boot = '0;
		seed = 32'h08f15a5e;
		n_errors = 0;
		num_checks = 0;
		repeat (15) @(posedge clock_i);
		#1;
		`ivm_chk("vector_valid_o in reset", 1'b0, valid)
		@(posedge clock_i);
		rst_i <= 1'b0;
		apply(5'h00, 64'h0, 1'b0, 1'b0, 17'h00000);
		// Each request line alone, reserved slots included
		for (int k = 0; k < 64; k++) begin
			apply(5'h00, 64'h1 << k, 1'b0, 1'b0, 17'h00000);
		end
		apply(5'h00, 64'h1 << 11, 1'b0, 1'b0, 17'h00000);
		`ivm_chk("watchdog address", 17'h00018, addr)
		apply(5'h00, 64'h1 << 63, 1'b0, 1'b0, 17'h00000);
		`ivm_chk("wakeup address", 17'h00080, addr)
		$display("test single requests done");
		// Reserved slots do not hide a higher real request; lowest real wins
		apply(5'h00, (64'h3f << 50) | (64'h1 << 60), 1'b0, 1'b0, 17'h00000);
		`ivm_chk("vector after reserved", 7'h3d, num)
		apply(5'h00, (64'h1 << 63) | (64'h1 << 4), 1'b1, 1'b0, 17'h1f000);
		$display("test priority done");
		// Every reset source, both fuse settings, select bit set
		for (int i = 0; i < 5; i++) begin
			for (int f = 0; f < 2; f++) begin
				seed = xs(seed);
				apply(5'h01 << i, {seed, ~seed}, 1'b1, f[0], 17'h1e000 | 17'(seed[11:0]));
			end
		end
		@(posedge clock_i);
		#1;
		`ivm_chk("core fetch address", boot, fetch_pc)
		$display("test reset sources done");
		// Random traffic, back to back
		repeat (300) begin
			seed = xs(seed);
			exp_v[0] = (seed[7:0] < 8'h10);
			seed = xs(seed);
			apply(exp_v[0] ? seed[4:0] : 5'h00, {seed, xs(seed)} << seed[13:8], seed[14], seed[15],
				seed[31:15]);
		end
		$display("test random done");
		// Reset in mid-run clears the outputs
		apply(5'h00, 64'h1 << 20, 1'b0, 1'b0, 17'h00000);
		@(posedge clock_i);
		rst_i <= 1'b1;
		@(posedge clock_i);
		#1;
		`ivm_chk("vector_valid_o mid reset", 1'b0, valid)
		`ivm_chk("vector_addr_o mid reset", 17'h00000, addr)
		`ivm_chk("core fetch count mid reset", 16'h0000, fetch_cnt)
		@(posedge clock_i);
		rst_i <= 1'b0;
		apply(5'h00, 64'h1 << 20, 1'b1, 1'b0, 17'h1ffff);
		$display("test mid reset done");
		close_out();
	end
endmodule : interrupt_vector_map_bench
